// File: src/reload_timer_pkg.sv
// Constants for the eight-bit reload timer
package reload_timer_pkg;
   // Byte addresses of the registers (16-bit registers in low half of word)
   localparam logic [15:0] CLK_SEL_ADDR  = 16'h4200;
   localparam logic [15:0] RELOAD_ADDR   = 16'h4202;
   localparam logic [15:0] COUNT_ADDR    = 16'h4204;
   localparam logic [15:0] CONTROL_ADDR  = 16'h4206;
   localparam int          ADDR_W        = 16;
   // Control field positions
   localparam int          RUN_BIT       = 0;
   localparam int          PRESET_BIT    = 1;
   localparam int          MODE_BIT      = 4;
   // Reset values
   localparam logic [3:0]  CLK_SEL_RST   = 4'h0;
   localparam logic [7:0]  RELOAD_RST    = 8'h00;
   localparam logic [7:0]  COUNT_RST     = 8'hff;
   // Divider code range
   localparam logic [3:0]  DIV_CODE_MAX  = 4'he;
   localparam int          PRESCALE_W    = 14;
   // UART sampling division
   localparam int          UART_DIV      = 16;
endpackage

// File: src/prescaler_if.sv
// Interface carrying the prescaler tick towards the timer core
`timescale 1ns/1ps
interface prescaler_if;
   logic [3:0] div_sel;
   logic       tick;
   modport src (input div_sel, output tick);
   modport dst (output div_sel, input tick);
endinterface

// File: src/timer_prescaler.sv
// Free-running prescaler that yields one-cycle count ticks
`timescale 1ns/1ps
module timer_prescaler
   import reload_timer_pkg::*;
(
   input  wire logic  pclk,
   input  wire logic  presetn,
   input  wire logic  enable,
   prescaler_if.src   pif
);
   logic [PRESCALE_W-1:0] div_ff;
   logic [PRESCALE_W-1:0] nxt_div;
   logic [PRESCALE_W-1:0] mask;
   logic                  tick_ff;

   // Mask of low bits that must be all ones for the chosen power of two
   assign mask    = PRESCALE_W'((15'h0001 << pif.div_sel) - 15'h0001);
   assign nxt_div = PRESCALE_W'(div_ff + 1'b1);

   // Divider counter and tick pulse
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_ff  <= '0;
         tick_ff <= 1'b0;
      end
      else
      begin
         div_ff  <= enable ? nxt_div : '0;
         tick_ff <= enable && (pif.div_sel <= DIV_CODE_MAX)
                    && ((div_ff & mask) == mask);
      end
   end
   assign pif.tick = tick_ff;
endmodule

// File: src/eight_bit_reload_timer.sv
// APB eight-bit reload timer with repeat and one-shot modes
//
// Function
// - Control bit 4 selects repeat (0, default) or one-shot (1) count mode.
// - Repeat mode reloads on each underflow and keeps counting until stopped.
// - One-shot mode reloads at first underflow, then clears run by itself.
// - Four-bit code 0..e divides pclk by 1..16384; code f gives no clock.
// - Eight-bit presettable down counter with eight-bit reload register.
// - Underflow period is reload value plus one count clock periods.
// - Writing 1 to control bit 1 presets counter; writing 0 does nothing.
// - Writing 1 to run bit counts down from preset or current value.
// - Underflow emits a pulse, reloads and raises the interrupt request.
// - Writing 0 to run bit halts; counter holds its value.
// - Preset written with run bit 1 while running reloads the counter and counting goes on; with run bit 0 it stops.
// - Underflow pulse also feeds the UART, which divides it by 16.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module eight_bit_reload_timer
   import reload_timer_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        prescaler_run,
   output logic             underflow_pulse,
   output logic             timer_irq,
   output logic             uart_clk_pulse
);
   typedef enum logic [0:0] {
      ST_STOP = 1'b0,
      ST_RUN  = 1'b1
   } run_state_e;

   prescaler_if pif ();

   logic [3:0]  clock_divider_sel_ff;
   logic [7:0]  reload_value_ff;
   logic [7:0]  count_ff;
   logic [7:0]  nxt_count;
   logic        count_mode_sel_ff;
   run_state_e  state_ff;
   run_state_e  nxt_state;
   logic        underflow_ff;
   logic        irq_ff;
   logic        uart_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;

   // APB decode: one wait state, answer in the second access-phase cycle
   logic        access;
   logic        wr_en;
   logic        low_lanes;
   logic        hit_clk;
   logic        hit_reload;
   logic        hit_count;
   logic        hit_ctl;
   logic        mapped;
   logic        wr_clk;
   logic        wr_reload;
   logic        wr_ctl;
   logic        preset_req;
   logic        run_wr_one;
   logic        run_wr_zero;
   logic        underflow;
   logic        count_step;
   logic [31:0] rd_mux;

   assign access      = psel && penable && !pready_ff;
   assign wr_en       = psel && penable && pready_ff && pwrite;  // Lands as pready stands high
   assign low_lanes   = pstrb[0];
   assign hit_clk     = paddr[ADDR_W-1:0] == CLK_SEL_ADDR;
   assign hit_reload  = paddr[ADDR_W-1:0] == RELOAD_ADDR;
   assign hit_count   = paddr[ADDR_W-1:0] == COUNT_ADDR;
   assign hit_ctl     = paddr[ADDR_W-1:0] == CONTROL_ADDR;
   assign mapped      = (paddr[31:ADDR_W] == '0) &&
                        (hit_clk || hit_reload || hit_count || hit_ctl);
   assign wr_clk      = wr_en && hit_clk && low_lanes && mapped;
   assign wr_reload   = wr_en && hit_reload && low_lanes && mapped;
   assign wr_ctl      = wr_en && hit_ctl && low_lanes && mapped;
   assign preset_req  = wr_ctl && pwdata[PRESET_BIT];
   assign run_wr_one  = wr_ctl && pwdata[RUN_BIT];
   assign run_wr_zero = wr_ctl && !pwdata[RUN_BIT];

   // Count step: a tick while running; a stop written at this edge freezes the counter
   assign count_step  = (state_ff == ST_RUN) && pif.tick && !run_wr_zero;
   // Underflow: a count step taken while the counter sits at zero
   assign underflow   = count_step && (count_ff == 8'h00);

   // Read mux; preset bit always reads zero, reserved bits read zero
   assign rd_mux = hit_clk    ? {28'h0000000, clock_divider_sel_ff} :
                   hit_reload ? {24'h000000, reload_value_ff} :
                   hit_count  ? {24'h000000, count_ff} :
                   hit_ctl    ? {27'h0000000, count_mode_sel_ff, 3'h0, state_ff == ST_RUN} :
                   32'h00000000;

   // Counter next value: preset wins over counting
   always_comb
   begin
      nxt_count = count_ff;
      if (preset_req)
         nxt_count = reload_value_ff;
      else if (underflow)
         nxt_count = reload_value_ff;
      else if (count_step)
         nxt_count = 8'(count_ff - 8'h01);
   end

   // Run state: software write, or self stop in one-shot mode
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_STOP:
         begin
            if (run_wr_one)
               nxt_state = ST_RUN;
         end
         ST_RUN:
         begin
            if (run_wr_zero)
               nxt_state = ST_STOP;
            else if (run_wr_one)
               nxt_state = ST_RUN;
            else if (underflow && count_mode_sel_ff)
               nxt_state = ST_STOP;
         end
         default:
            nxt_state = ST_STOP;
      endcase
   end

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clock_divider_sel_ff <= CLK_SEL_RST;
         reload_value_ff      <= RELOAD_RST;
         count_mode_sel_ff    <= 1'b0;
      end
      else
      begin
         if (wr_clk)
            clock_divider_sel_ff <= pwdata[3:0];
         if (wr_reload)
            reload_value_ff <= pwdata[7:0];
         if (wr_ctl)
            count_mode_sel_ff <= pwdata[MODE_BIT];
      end
   end

   // Counter and run state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_ff <= COUNT_RST;
         state_ff <= ST_STOP;
      end
      else
      begin
         count_ff <= nxt_count;
         state_ff <= nxt_state;
      end
   end

   // Event outputs, one pclk each, all from the same underflow
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         underflow_ff <= 1'b0;
         irq_ff       <= 1'b0;
         uart_ff      <= 1'b0;
      end
      else
      begin
         underflow_ff <= underflow;
         irq_ff       <= underflow;
         uart_ff      <= underflow;
      end
   end

   // APB answer registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_ff  <= 32'h00000000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pready_ff  <= access;
         pslverr_ff <= access && !mapped;
         if (access && !pwrite)
            prdata_ff <= mapped ? rd_mux : 32'h00000000;
      end
   end

   assign pif.div_sel = clock_divider_sel_ff;

   timer_prescaler i_timer_prescaler (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (prescaler_run),
      .pif     (pif)
   );

   assign prdata          = prdata_ff;
   assign pready          = pready_ff;
   assign pslverr         = pslverr_ff;
   assign underflow_pulse = underflow_ff;
   assign timer_irq       = irq_ff;
   assign uart_clk_pulse  = uart_ff;

   // Checks
   sequence start_seq;
      run_wr_one && (state_ff == ST_STOP);
   endsequence

   run_on_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      start_seq |=> state_ff == ST_RUN)
      else $error("run bit write did not start timer");
   stop_on_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      run_wr_zero && !preset_req |=> (state_ff == ST_STOP) && $stable(count_ff))
      else $error("stop write did not halt timer");
   hold_when_stopped_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state_ff == ST_STOP) && !preset_req |=> $stable(count_ff))
      else $error("counter moved while stopped");
   preset_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      preset_req |=> count_ff == $past(reload_value_ff))
      else $error("preset did not load reload value");
   preset_keeps_run_a: assert property (@(posedge pclk) disable iff (!presetn)
      preset_req && !run_wr_zero && (state_ff == ST_RUN) |=> state_ff == ST_RUN)
      else $error("preset while running stopped timer");
   oneshot_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      underflow && count_mode_sel_ff && !wr_ctl |=>
         (state_ff == ST_STOP) && (count_ff == $past(reload_value_ff)))
      else $error("one-shot did not stop with reload");
   repeat_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
      underflow && !count_mode_sel_ff && !wr_ctl |=> state_ff == ST_RUN)
      else $error("repeat mode stopped at underflow");
   pulse_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      underflow |=> underflow_pulse && timer_irq && uart_clk_pulse
         ##1 (underflow_pulse == $past(underflow)))
      else $error("underflow pulse or request missing");
   decrement_a: assert property (@(posedge pclk) disable iff (!presetn)
      count_step && !underflow && !preset_req
         |=> count_ff == 8'($past(count_ff) - 8'h01))
      else $error("counter did not decrement");
   no_tick_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
      clock_divider_sel_ff == 4'hf |=> !pif.tick)
      else $error("tick with reserved clock code");

   // Checks on register contents, the count clock and the event pulses
   reload_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !wr_reload |=> $stable(reload_value_ff))
      else $error("reload value changed without a write");
   clk_sel_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !wr_clk |=> $stable(clock_divider_sel_ff))
      else $error("clock select changed without a write");
   mode_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !wr_ctl |=> $stable(count_mode_sel_ff))
      else $error("count mode changed without a write");

   sequence code1_tick_seq;
      (clock_divider_sel_ff == 4'h1) ##1
      (pif.tick && prescaler_run && (clock_divider_sel_ff == 4'h1)) ##1
      (prescaler_run && (clock_divider_sel_ff == 4'h1));
   endsequence

   tick_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
      code1_tick_seq |-> !pif.tick ##1 pif.tick)
      else $error("count clock at code 1 not every second cycle");
   pulse_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      !underflow |=> !underflow_pulse && !timer_irq && !uart_clk_pulse)
      else $error("event pulse without an underflow");

   // Checks on the bus answer
   write_at_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en |-> pready)
      else $error("register write outside the ready cycle");
   ready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready stood longer than one cycle");
   slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error response without ready");
   unmapped_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr && !$past(pwrite) |-> prdata == 32'h00000000)
      else $error("unmapped read returned nonzero data");
endmodule

// File: dv/eight_bit_reload_timer_bench.sv
// Self-checking bench for the eight-bit reload timer over APB
`timescale 1ns/1ps
module eight_bit_reload_timer_bench;
   import reload_timer_pkg::*;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        prescaler_run;
   logic        underflow_pulse;
   logic        timer_irq;
   logic        uart_clk_pulse;
   int          miscompares;
   int          n_compared;
   logic [31:0] rd;
   logic        err;
   int          n;
   logic [3:0]  codes [5] = '{4'h0, 4'h0, 4'h1, 4'h3, 4'h4};
   logic [7:0]  loads [5] = '{8'h00, 8'hff, 8'h01, 8'h02, 8'h01};

   eight_bit_reload_timer i_eight_bit_reload_timer (
      .pclk            (pclk),
      .presetn         (presetn),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .pstrb           (pstrb),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .prescaler_run   (prescaler_run),
      .underflow_pulse (underflow_pulse),
      .timer_irq       (timer_irq),
      .uart_clk_pulse  (uart_clk_pulse)
   );

   // Clock of 100 MHz
   always #5 pclk = ~pclk;

   // Verdict and end of run
   task automatic end_sim();
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Compare seen against expected
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {16'h0000, a};
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20)
      begin
         k++;
         @(posedge pclk);
      end
      if (pready !== 1'b1)
      begin
         miscompares++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Read and compare one register
   task automatic rchk(input string what, input logic [15:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 4'h0);
      check(what, rd, exp);
   endtask

   // Edges up to and including the next underflow pulse
   // A pulse that is needed and never comes counts as a mismatch and ends the run
   task automatic wait_uf(input int bound, input bit need);
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (underflow_pulse !== 1'b1 && n < bound);
      if (need && underflow_pulse !== 1'b1)
      begin
         miscompares++;
         end_sim();
      end
   endtask

   // Stop, then mode, clock, reload, preset and run in that order
   task automatic setup(input logic [3:0] c, input logic [7:0] r, input logic m);
      apb(1'b1, CONTROL_ADDR, 32'h0, 4'hf);
      apb(1'b1, CONTROL_ADDR, 32'(m) << MODE_BIT, 4'hf);
      apb(1'b1, CLK_SEL_ADDR, {28'h0, c}, 4'hf);
      apb(1'b1, RELOAD_ADDR, {24'h0, r}, 4'hf);
      apb(1'b1, CONTROL_ADDR, (32'(m) << MODE_BIT) | 32'h2, 4'hf);
      apb(1'b1, CONTROL_ADDR, (32'(m) << MODE_BIT) | 32'h1, 4'hf);
   endtask

   // Main sequence
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      prescaler_run = 1'b1;
      miscompares = 0;
      n_compared = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk("clk_sel", CLK_SEL_ADDR, 32'(CLK_SEL_RST));
      check("okay", 32'(err), 32'h0);
      rchk("reload", RELOAD_ADDR, 32'(RELOAD_RST));
      rchk("count", COUNT_ADDR, 32'(COUNT_RST));
      rchk("control", CONTROL_ADDR, 32'h0);
      rchk("unmapped", 16'h4208, 32'h0);
      check("slverr", 32'(err), 32'h1);
      apb(1'b1, RELOAD_ADDR, 32'h5a, 4'he);
      rchk("strobe", RELOAD_ADDR, 32'h0);
      apb(1'b1, RELOAD_ADDR, 32'h1a5, 4'hf);
      rchk("reload_wr", RELOAD_ADDR, 32'ha5);
      apb(1'b1, COUNT_ADDR, 32'h12, 4'hf);
      rchk("count_ro", COUNT_ADDR, 32'hff);
      apb(1'b1, CONTROL_ADDR, 32'h0, 4'hf);
      rchk("no_preset", COUNT_ADDR, 32'hff);
      apb(1'b1, CONTROL_ADDR, 32'h2, 4'hf);
      rchk("preset", COUNT_ADDR, 32'ha5);
      rchk("preset_rd0", CONTROL_ADDR, 32'h0);
      $display("Test registers done");
      // Repeat-mode period per divider code and reload
      for (int i = 0; i < 5; i++)
      begin
         setup(codes[i], loads[i], 1'b0);
         wait_uf(5000, 1'b1);
         wait_uf(5000, 1'b1);
         check("period", n, (32'(loads[i]) + 1) << codes[i]);
         check("irq", 32'(timer_irq), 32'h1);
         check("uart", 32'(uart_clk_pulse), 32'h1);
      end
      setup(4'hf, 8'h00, 1'b0);
      wait_uf(100, 1'b0);
      check("reserved", 32'(underflow_pulse), 32'h0);
      check("reserved_irq", 32'(timer_irq), 32'h0);
      // Without the prescaler running there is no count clock
      prescaler_run <= 1'b0;
      setup(4'h0, 8'h00, 1'b0);
      wait_uf(50, 1'b0);
      check("no_prescaler", 32'(underflow_pulse), 32'h0);
      prescaler_run <= 1'b1;
      $display("Test periods done");
      // Stop holds the counter
      setup(4'h0, 8'hc8, 1'b0);
      repeat (20) @(posedge pclk);
      apb(1'b1, CONTROL_ADDR, 32'h0, 4'hf);
      apb(1'b0, COUNT_ADDR, 32'h0, 4'h0);
      n = int'(rd);
      repeat (30) @(posedge pclk);
      rchk("hold", COUNT_ADDR, 32'(n));
      check("counted", 32'(n < 200), 32'h1);
      apb(1'b1, CONTROL_ADDR, 32'h1, 4'hf);
      repeat (5) @(posedge pclk);
      apb(1'b0, COUNT_ADDR, 32'h0, 4'h0);
      check("resume", 32'(rd < 32'(n)), 32'h1);
      // Preset written with the run bit set while running keeps it running
      apb(1'b1, CONTROL_ADDR, 32'h3, 4'hf);
      rchk("still_run", CONTROL_ADDR, 32'h1);
      wait_uf(300, 1'b1);
      check("run_uf", 32'(underflow_pulse), 32'h1);
      $display("Test stop done");
      // One-shot stops after one underflow with counter preset
      setup(4'h0, 8'h05, 1'b1);
      wait_uf(100, 1'b1);
      // Reload plus one count periods, then one cycle for the registered pulse
      check("os_period", n, 32'h5 + 32'h1 + 32'h1);
      rchk("os_ctl", CONTROL_ADDR, 32'h1 << MODE_BIT);
      rchk("os_count", COUNT_ADDR, 32'h5);
      wait_uf(60, 1'b0);
      check("os_once", 32'(underflow_pulse), 32'h0);
      check("os_irq", 32'(timer_irq), 32'h0);
      $display("Test one-shot done");
      // Reset in mid-run stops the timer and restores count, control and reload
      setup(4'h0, 8'h10, 1'b0);
      repeat (3) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check("rst_pulse", 32'(underflow_pulse), 32'h0);
      presetn <= 1'b1;
      rchk("rst_count", COUNT_ADDR, 32'(COUNT_RST));
      rchk("rst_ctl", CONTROL_ADDR, 32'h0);
      rchk("rst_reload", RELOAD_ADDR, 32'(RELOAD_RST));
      wait_uf(30, 1'b0);
      check("rst_stopped", 32'(underflow_pulse), 32'h0);
      $display("Test reset done");
      end_sim();
   end
endmodule
